/* core/rcn_pkg.sv */
package rcn_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W = 13;
  localparam int BIT_ZERO_MIN_NS = 10000;
  localparam int BIT_ONE_MIN_NS = 30000;
  localparam int FRAME_GAP_MAX_NS = 40000;
  localparam int MARKER_LOW_NS = 20000;
  localparam int MARKER_PERIOD_NS = 40000;
  localparam int END_PULSE_BASE_NS = 5000;
  localparam logic [CNT_W-1:0] BIT_ZERO_MIN_CYC =
    CNT_W'((BIT_ZERO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BIT_ONE_MIN_CYC =
    CNT_W'((BIT_ONE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FRAME_GAP_MAX_CYC = CNT_W'(FRAME_GAP_MAX_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MARKER_LOW_CYC = CNT_W'(MARKER_LOW_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MARKER_PERIOD_CYC = CNT_W'(MARKER_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] END_PULSE_BASE_CYC = CNT_W'(END_PULSE_BASE_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;

  // ----------------------------------------------------------------
  // frame and register layout
  // ----------------------------------------------------------------
  localparam int REG_W = 12;
  localparam int SHIFT_W = 14;
  localparam logic [3:0] FRAME_LAST_BIT = 4'h0e;
  localparam int FR_OFF_BIT = 13;
  localparam int FR_SEL_BIT = 12;
  localparam logic [REG_W-1:0] OPCFG_RESET = 12'h0119;
  localparam logic [REG_W-1:0] BOUNDS_RESET = 12'h0569;
  localparam int OP_BAUD_HI = 11;
  localparam int OP_BAUD_LO = 10;
  localparam int OP_CHK_HI = 9;
  localparam int OP_CHK_LO = 8;
  localparam int OP_MOD = 7;
  localparam int OP_SLEEP_HI = 6;
  localparam int OP_SLEEP_LO = 2;
  localparam int OP_STRETCH = 1;
  localparam int OP_SQUELCH = 0;

  // ----------------------------------------------------------------
  // decoded factors
  // ----------------------------------------------------------------
  localparam logic [3:0] SCALE_R0 = 4'h8;
  localparam logic [3:0] SCALE_R1 = 4'h4;
  localparam logic [3:0] SCALE_R2 = 4'h2;
  localparam logic [3:0] SCALE_R3 = 4'h1;
  localparam logic [3:0] NCHK_0 = 4'h0;
  localparam logic [3:0] NCHK_1 = 4'h3;
  localparam logic [3:0] NCHK_2 = 4'h6;
  localparam logic [3:0] NCHK_3 = 4'h9;
  localparam logic [3:0] SLEEP_X1 = 4'h1;
  localparam logic [3:0] SLEEP_X8 = 4'h8;

  typedef enum logic [1:0] {
    RCN_POLL = 2'b00,
    RCN_STARTUP = 2'b01,
    RCN_RECV = 2'b11,
    RCN_SQUELCH = 2'b10
  } rcn_mode_e;

  typedef struct packed {
    rcn_mode_e mode;
    logic [2:0] dsync;
    logic [2:0] psync;
    logic dat_f;
    logic pol_f;
    logic drive;
    logic [3:0] drv_hist;
    logic [CNT_W-1:0] lowcnt;
    logic [CNT_W-1:0] gapcnt;
    logic inframe;
    logic [3:0] nbit;
    logic [SHIFT_W-1:0] sh;
    logic [REG_W-1:0] opcfg;
    logic [REG_W-1:0] bounds;
    logic marker;
    logic wr_op;
    logic wr_lim;
    logic [CNT_W-1:0] mcnt;
    logic [CNT_W-1:0] pcnt;
    logic [3:0] scale;
    logic [3:0] nchk;
    logic [3:0] xsleep;
    logic skip_sleep;
    logic chk_en;
    logic off_pulse;
  } rcn_state_s;

endpackage : rcn_pkg

/* core/rcn_ctrl.sv */
// Contract
// RQ1: squelch set: stream end enters check, line high; code does so only with polling pin high
// RQ2: automatic squelch returns to receive on check
// RQ3: high last period gives one range-scaled pulse
// RQ4: squelch clear: noise passes after stream end
// RQ5: polling pin low: off goes startup, skips sleep
// RQ6: host drives polling pin low, then high
// RQ7: host picks method by line code
// RQ8: two 12-bit registers written over data line
// RQ9: supply drop shows marker; host reprograms both
// RQ10: reset loads both registers with defaults
// RQ11: first bit one means off command
// RQ12: second bit selects operating or bounds register
// RQ13: commit only when stop bit is zero
// RQ14: fixed field layout, most significant bit first
// RQ15: documented default value for every field
// RQ16: baud range selects bound scale 8/4/2/1
// RQ17: check count field gives 0/3/6/9 bits
// RQ18: squelch bit one enables suppression, default
// RQ19: sleep stretch multiplies sleep by 1 or 8
// RQ20: frame shifted in, committed atomically after stop
`timescale 1ns/10ps
module rcn_ctrl
  import rcn_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe_out,
  input wire logic polling_n_in,
  input wire logic dem_in,
  input wire logic stream_end_in,
  input wire logic check_ok_in,
  input wire logic check_fail_in,
  input wire logic sleep_done_in,
  input wire logic supply_drop_in,
  output rcn_mode_e mode_out,
  output logic [REG_W-1:0] operating_config_out,
  output logic [REG_W-1:0] bit_check_bounds_out,
  output logic [3:0] bound_scale_out,
  output logic [3:0] check_bits_out,
  output logic [3:0] sleep_factor_out,
  output logic skip_sleep_out,
  output logic check_enable_out,
  output logic off_cmd_out,
  output logic supply_loss_pattern_out
);

  // ----------------------------------------------------------------
  // field decoders
  // ----------------------------------------------------------------
  function automatic logic [3:0] bound_scale_of(input logic [REG_W-1:0] op);
    unique case (op[OP_BAUD_HI:OP_BAUD_LO])
      2'b00: bound_scale_of = SCALE_R0;
      2'b01: bound_scale_of = SCALE_R1;
      2'b10: bound_scale_of = SCALE_R2;
      2'b11: bound_scale_of = SCALE_R3;
    endcase
  endfunction : bound_scale_of

  function automatic logic [3:0] check_bits_of(input logic [REG_W-1:0] op);
    unique case (op[OP_CHK_HI:OP_CHK_LO])
      2'b00: check_bits_of = NCHK_0;
      2'b01: check_bits_of = NCHK_1;
      2'b10: check_bits_of = NCHK_2;
      2'b11: check_bits_of = NCHK_3;
    endcase
  endfunction : check_bits_of

  rcn_state_s st;
  rcn_state_s next_st;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic pol_rise;
    logic host_quiet;
    logic bit_done;
    logic bit_val;
    logic off_cmd;
    logic commit_op;
    logic commit_lim;
    logic [CNT_W-1:0] pulse_len;
    pol_rise = 1'b0;
    host_quiet = 1'b0;
    bit_done = 1'b0;
    bit_val = 1'b0;
    off_cmd = 1'b0;
    commit_op = 1'b0;
    commit_lim = 1'b0;
    pulse_len = CNT_ZERO;
    next_st = st;
    next_st.off_pulse = 1'b0;

    // three-stage pin synchronisers; a level counts once stages two and three agree
    next_st.dsync = {st.dsync[1:0], data_in};
    next_st.psync = {st.psync[1:0], polling_n_in};
    if (st.dsync[1] == st.dsync[2]) begin
      next_st.dat_f = st.dsync[2];
    end
    if (st.psync[1] == st.psync[2]) begin
      next_st.pol_f = st.psync[2];
    end
    pol_rise = !st.pol_f && next_st.pol_f;

    // own drive echoes back through the synchroniser, so host pulses are
    // only measured once our pull-down has been released for a while
    next_st.drv_hist = {st.drv_hist[2:0], st.drive};
    host_quiet = (st.drv_hist == 4'h0) && !st.drive;

    // ----------------------------------------------------------------
    // serial frame receiver
    // ----------------------------------------------------------------
    if (host_quiet && !st.dat_f) begin
      if (st.lowcnt != {CNT_W{1'b1}}) begin
        next_st.lowcnt = st.lowcnt + CNT_ONE;
      end
      next_st.gapcnt = CNT_ZERO;
    end else begin
      next_st.lowcnt = CNT_ZERO;
      if (host_quiet && st.dat_f && st.lowcnt >= BIT_ZERO_MIN_CYC) begin
        bit_done = 1'b1;
        bit_val = (st.lowcnt >= BIT_ONE_MIN_CYC);
      end
      if (st.inframe) begin
        next_st.gapcnt = st.gapcnt + CNT_ONE;
        // a stalled frame is dropped so a later frame starts clean
        if (st.gapcnt >= FRAME_GAP_MAX_CYC) begin
          next_st.inframe = 1'b0;
          next_st.nbit = 4'h0;
        end
      end
    end

    if (bit_done) begin
      next_st.gapcnt = CNT_ZERO;
      if (!st.inframe || st.nbit == 4'h0) begin
        if (bit_val) begin
          off_cmd = 1'b1; // [RQ11]
          next_st.inframe = 1'b0;
          next_st.nbit = 4'h0;
        end else begin
          next_st.inframe = 1'b1;
          next_st.nbit = 4'h1;
          next_st.sh = {st.sh[SHIFT_W-2:0], bit_val};
        end
      end else if (st.nbit == FRAME_LAST_BIT) begin
        next_st.inframe = 1'b0;
        next_st.nbit = 4'h0;
        if (!bit_val) begin // [RQ13] [RQ20]
          commit_op = st.sh[FR_SEL_BIT]; // [RQ12]
          commit_lim = !st.sh[FR_SEL_BIT]; // [RQ12]
        end
      end else begin
        next_st.nbit = st.nbit + 4'h1;
        next_st.sh = {st.sh[SHIFT_W-2:0], bit_val}; // [RQ20]
      end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    if (commit_op) begin
      next_st.opcfg = st.sh[REG_W-1:0]; // [RQ8] [RQ14]
      next_st.wr_op = 1'b1;
    end
    if (commit_lim) begin
      next_st.bounds = st.sh[REG_W-1:0]; // [RQ8] [RQ14]
      next_st.wr_lim = 1'b1;
    end
    if (next_st.wr_op && next_st.wr_lim) begin
      next_st.marker = 1'b0;
    end
    // a drop wins over any commit in the same cycle: contents are suspect
    if (supply_drop_in) begin
      next_st.opcfg = OPCFG_RESET; // [RQ10]
      next_st.bounds = BOUNDS_RESET; // [RQ10]
      next_st.marker = 1'b1; // [RQ9]
      next_st.wr_op = 1'b0;
      next_st.wr_lim = 1'b0;
    end

    next_st.scale = bound_scale_of(next_st.opcfg); // [RQ16]
    next_st.nchk = check_bits_of(next_st.opcfg); // [RQ17]
    next_st.xsleep = next_st.opcfg[OP_STRETCH] ? SLEEP_X8 : SLEEP_X1; // [RQ19]
    next_st.off_pulse = off_cmd;

    // ----------------------------------------------------------------
    // mode sequencing
    // ----------------------------------------------------------------
    unique case (st.mode)
      RCN_POLL: begin
        if (!st.pol_f || sleep_done_in) begin
          next_st.mode = RCN_STARTUP;
        end
      end
      RCN_STARTUP: begin
        if (check_ok_in) begin
          next_st.mode = RCN_RECV;
        end else if (check_fail_in && st.pol_f) begin
          next_st.mode = RCN_POLL;
        end
      end
      RCN_RECV: begin
        if (off_cmd) begin
          next_st.mode = st.pol_f ? RCN_POLL : RCN_STARTUP; // [RQ5]
        end else if (pol_rise) begin
          next_st.mode = RCN_POLL; // [RQ6]
        end else if (stream_end_in && st.opcfg[OP_SQUELCH] && st.pol_f) begin
          next_st.mode = RCN_SQUELCH; // [RQ1] [RQ18]
        end
      end
      RCN_SQUELCH: begin
        if (off_cmd) begin
          next_st.mode = st.pol_f ? RCN_POLL : RCN_STARTUP;
        end else if (check_ok_in) begin
          next_st.mode = RCN_RECV; // [RQ2]
        end
      end
    endcase
    // the pin forces startup regardless of programmed sleep; receiving still waits for check_ok_in
    next_st.skip_sleep = !next_st.pol_f; // [RQ5]
    next_st.chk_en = (next_st.mode == RCN_STARTUP) || (next_st.mode == RCN_SQUELCH);

    // ----------------------------------------------------------------
    // data line drive (pull-down only)
    // ----------------------------------------------------------------
    pulse_len = CNT_W'(END_PULSE_BASE_CYC * st.scale); // [RQ3]
    if (st.pcnt != CNT_ZERO) begin
      next_st.pcnt = st.pcnt - CNT_ONE;
    end
    if (st.mode == RCN_RECV && stream_end_in && dem_in) begin
      next_st.pcnt = pulse_len; // [RQ3]
    end

    if (st.marker) begin
      if (st.mcnt >= MARKER_PERIOD_CYC - CNT_ONE) begin
        next_st.mcnt = CNT_ZERO;
      end else begin
        next_st.mcnt = st.mcnt + CNT_ONE;
      end
    end else begin
      next_st.mcnt = CNT_ZERO;
    end

    if (st.marker && st.mode != RCN_POLL) begin
      next_st.drive = (st.mcnt < MARKER_LOW_CYC); // [RQ9]
    end else if (next_st.pcnt != CNT_ZERO) begin
      next_st.drive = 1'b1; // [RQ3]
    end else if (next_st.mode == RCN_RECV) begin
      // after stream end with squelch clear, noise passes unchanged
      next_st.drive = !dem_in; // [RQ4]
    end else begin
      next_st.drive = 1'b0; // [RQ1]
    end
    // a host bit cell in progress is not disturbed by our drive, except by the end pulse or the marker
    if (st.inframe || (host_quiet && !st.dat_f)) begin
      if (next_st.pcnt == CNT_ZERO && !st.marker) begin
        next_st.drive = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
      st.mode <= RCN_POLL;
      st.dsync <= 3'h7;
      st.psync <= 3'h7;
      st.dat_f <= 1'b1;
      st.pol_f <= 1'b1;
      st.opcfg <= OPCFG_RESET; // [RQ10] [RQ15]
      st.bounds <= BOUNDS_RESET; // [RQ10] [RQ15]
      st.scale <= SCALE_R0; // [RQ15]
      st.nchk <= NCHK_1; // [RQ15]
      st.xsleep <= SLEEP_X1; // [RQ15]
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    data_out = 1'b0;
    data_oe_out = st.drive;
    mode_out = st.mode;
    operating_config_out = st.opcfg;
    bit_check_bounds_out = st.bounds;
    bound_scale_out = st.scale;
    check_bits_out = st.nchk;
    sleep_factor_out = st.xsleep;
    skip_sleep_out = st.skip_sleep;
    check_enable_out = st.chk_en;
    off_cmd_out = st.off_pulse;
    supply_loss_pattern_out = st.marker;
  end

endmodule : rcn_ctrl

/* sim/rcn_ctrl_properties.sv */
`timescale 1ns/10ps
module rcn_ctrl_properties
  import rcn_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic stream_end_in,
  input wire logic check_ok_in,
  input wire logic supply_drop_in,
  input wire rcn_mode_e mode_out,
  input wire logic [REG_W-1:0] operating_config_out,
  input wire logic [REG_W-1:0] bit_check_bounds_out,
  input wire logic [3:0] bound_scale_out,
  input wire logic [3:0] check_bits_out,
  input wire logic [3:0] sleep_factor_out,
  input wire logic skip_sleep_out,
  input wire logic check_enable_out,
  input wire logic off_cmd_out,
  input wire logic supply_loss_pattern_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  // ----------------------------------------------------------------
  // decoded fields and mode sequencing
  // ----------------------------------------------------------------
  property p_scale;
    bound_scale_out == (SCALE_R0 >> operating_config_out[OP_BAUD_HI:OP_BAUD_LO]);
  endproperty
  a_scale: assert property (p_scale) else $error("bound scale wrong");
  property p_nchk;
    check_bits_out == 4'(operating_config_out[OP_CHK_HI:OP_CHK_LO] * 3);
  endproperty
  a_nchk: assert property (p_nchk) else $error("check count wrong");
  property p_sleep;
    sleep_factor_out == (operating_config_out[OP_STRETCH] ? SLEEP_X8 : SLEEP_X1);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep factor wrong");
  property p_drop;
    supply_drop_in |=> operating_config_out == OPCFG_RESET
      && bit_check_bounds_out == BOUNDS_RESET && supply_loss_pattern_out;
  endproperty
  a_drop: assert property (p_drop) else $error("supply drop not handled");
  property p_off_pulse;
    off_cmd_out |=> !off_cmd_out;
  endproperty
  a_off_pulse: assert property (p_off_pulse) else $error("off pulse too long");
  property p_off_mode;
    off_cmd_out |-> ##[0:1] mode_out inside {RCN_POLL, RCN_STARTUP};
  endproperty
  a_off_mode: assert property (p_off_mode) else $error("off left mode wrong");
  property p_sq_entry;
    mode_out == RCN_SQUELCH && $past(mode_out) != RCN_SQUELCH
      |-> $past(stream_end_in) && operating_config_out[OP_SQUELCH];
  endproperty
  a_sq_entry: assert property (p_sq_entry) else $error("bad squelch entry");
  property p_sq_exit;
    mode_out == RCN_SQUELCH && check_ok_in |=> mode_out == RCN_RECV;
  endproperty
  a_sq_exit: assert property (p_sq_exit) else $error("squelch exit missed");
  property p_noise;
    mode_out == RCN_RECV && stream_end_in && !operating_config_out[OP_SQUELCH]
      |=> mode_out != RCN_SQUELCH;
  endproperty
  a_noise: assert property (p_noise) else $error("squelch while disabled");
  property p_chk_en;
    check_enable_out == (mode_out == RCN_STARTUP || mode_out == RCN_SQUELCH);
  endproperty
  a_chk_en: assert property (p_chk_en) else $error("check enable wrong");
  property p_wake;
    mode_out == RCN_POLL && skip_sleep_out |-> ##[1:2] mode_out == RCN_STARTUP;
  endproperty
  a_wake: assert property (p_wake) else $error("pin low did not wake");
endmodule : rcn_ctrl_properties

bind rcn_ctrl rcn_ctrl_properties u_props (.sys_clk_in, .arst_n_in, .stream_end_in,
  .check_ok_in, .supply_drop_in, .mode_out, .operating_config_out, .bit_check_bounds_out,
  .bound_scale_out, .check_bits_out, .sleep_factor_out, .skip_sleep_out, .check_enable_out,
  .off_cmd_out, .supply_loss_pattern_out);

/* sim/rcn_host_model.sv */
`timescale 1ns/10ps
module rcn_host_model
  import rcn_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic dev_oe_in,
  output logic host_oe_out
);
  // ----------------------------------------------------------------
  // serial frames: host pulls the pulled-up wire low per bit
  // ----------------------------------------------------------------
  initial host_oe_out = 1'b0;
  // widths sit clear of both thresholds so sync latency never flips a bit
  task automatic send(input logic [14:0] f, input int n);
    int q;
    for (int i = 0; i < n; i++) begin
      q = 0;
      while (q < 8) begin
        @(negedge sys_clk_in);
        q = (dev_oe_in === 1'b0) ? q + 1 : 0;
      end
      host_oe_out = 1'b1;
      repeat (f[14-i] ? 3100 : 1100) @(negedge sys_clk_in);
      host_oe_out = 1'b0;
    end
    repeat (20) @(negedge sys_clk_in);
  endtask : send
endmodule : rcn_host_model

/* sim/testbench.sv */
`timescale 1ns/10ps
module testbench
  import rcn_pkg::*;
;
  logic sys_clk_in, arst_n_in, data_in, data_out, data_oe_out, polling_n_in, dem_in;
  logic stream_end_in, check_ok_in, check_fail_in, sleep_done_in, supply_drop_in, host_oe;
  rcn_mode_e mode_out;
  logic [REG_W-1:0] operating_config_out, bit_check_bounds_out, exp_op, exp_bd, d;
  logic [3:0] bound_scale_out, check_bits_out, sleep_factor_out;
  logic skip_sleep_out, check_enable_out, off_cmd_out, supply_loss_pattern_out;
  logic [31:0] seed = 32'h0001_3ca5;
  int n_fail = 0;
  int num_checks = 0;
  int n_off = 0;
  int k;

  assign data_in = ~(host_oe | data_oe_out);
  rcn_ctrl DUT (.sys_clk_in, .arst_n_in, .data_in, .data_out, .data_oe_out, .polling_n_in,
    .dem_in, .stream_end_in, .check_ok_in, .check_fail_in, .sleep_done_in, .supply_drop_in,
    .mode_out, .operating_config_out, .bit_check_bounds_out, .bound_scale_out,
    .check_bits_out, .sleep_factor_out, .skip_sleep_out, .check_enable_out, .off_cmd_out,
    .supply_loss_pattern_out);
  rcn_host_model hm (.sys_clk_in(sys_clk_in), .dev_oe_in(data_oe_out), .host_oe_out(host_oe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic check_regs();
    check("opcfg", operating_config_out, exp_op);
    check("bounds", bit_check_bounds_out, exp_bd);
    check("scale", bound_scale_out, 8 >> exp_op[11:10]);
    check("nchk", check_bits_out, 3 * exp_op[9:8]);
    check("sfac", sleep_factor_out, exp_op[1] ? 8 : 1);
  endtask : check_regs
  task automatic wait_mode(input rcn_mode_e m);
    k = 0;
    while (mode_out !== m && k < 40) begin
      @(negedge sys_clk_in);
      k++;
    end
    check("mode", mode_out, m);
  endtask : wait_mode
  task automatic pulse(ref logic s);
    @(negedge sys_clk_in);
    s = 1'b1;
    @(negedge sys_clk_in);
    s = 1'b0;
  endtask : pulse
  // the bench model only commits a frame whose stop bit is zero
  task automatic wr(input logic sel, input logic [11:0] v, input logic stop);
    hm.send({1'b0, sel, v, stop}, 15);
    if (!stop && sel) exp_op = v;
    if (!stop && !sel) exp_bd = v;
    check_regs();
  endtask : wr
  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  always @(posedge sys_clk_in) begin
    if (off_cmd_out === 1'b1) n_off++;
  end
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    // frames cost about 1100 cycles per zero and 3100 per one bit, so the
    // register writes below keep few ones to stay inside this budget
    repeat (95000) @(posedge sys_clk_in);
    n_fail++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n_in, dem_in, stream_end_in, check_ok_in, check_fail_in} = 5'h00;
    {sleep_done_in, supply_drop_in, polling_n_in} = 3'b001;
    exp_op = {2'b00, 2'b01, 1'b0, 5'b00110, 1'b0, 1'b1};
    exp_bd = {6'b010101, 6'b101001};
    repeat (12) @(negedge sys_clk_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    check_regs();
    polling_n_in = 1'b0;
    wait_mode(RCN_STARTUP);
    check("skip", skip_sleep_out, 1);
    pulse(check_ok_in);
    wait_mode(RCN_RECV);
    dem_in = 1'b1;
    hm.send(15'h4000, 1);
    wait_mode(RCN_STARTUP);
    check("offs", n_off, 1);
    pulse(check_ok_in);
    wait_mode(RCN_RECV);
    polling_n_in = 1'b1;
    wait_mode(RCN_POLL);
    pulse(sleep_done_in);
    wait_mode(RCN_STARTUP);
    pulse(check_ok_in);
    wait_mode(RCN_RECV);
    dem_in = 1'b0;
    pulse(stream_end_in);
    wait_mode(RCN_SQUELCH);
    repeat (10) @(negedge sys_clk_in);
    check("sq_line", data_oe_out, 0);
    check("sq_dout", data_out, 0);
    pulse(check_ok_in);
    wait_mode(RCN_RECV);
    dem_in = 1'b1;
    pulse(stream_end_in);
    k = 0;
    repeat (4100) begin
      if (data_oe_out === 1'b1) k++;
      @(negedge sys_clk_in);
    end
    check("end_pulse", k >= 3999 && k <= 4001, 1);
    pulse(check_ok_in);
    wait_mode(RCN_RECV);
    hm.send(15'h4000, 1);
    wait_mode(RCN_POLL);
    pulse(supply_drop_in);
    check("marker", supply_loss_pattern_out, 1);
    d = 12'(xs());
    wr(1'b1, d & 12'hc06, 1'b0);
    check("marker", supply_loss_pattern_out, 1);
    d = 12'(xs());
    wr(1'b0, d & 12'h303, 1'b0);
    check("marker", supply_loss_pattern_out, 0);
    wr(1'b0, (exp_bd == 12'h000) ? 12'h001 : 12'h000, 1'b1);
    pulse(sleep_done_in);
    pulse(check_ok_in);
    wait_mode(RCN_RECV);
    repeat (16) begin
      @(negedge sys_clk_in);
      dem_in = 1'(xs());
    end
    pulse(stream_end_in);
    repeat (8) @(negedge sys_clk_in);
    check("noise_mode", mode_out, RCN_RECV);
    pulse(supply_drop_in);
    exp_op = {2'b00, 2'b01, 1'b0, 5'b00110, 1'b0, 1'b1};
    exp_bd = {6'b010101, 6'b101001};
    check_regs();
    check("marker", supply_loss_pattern_out, 1);
    print_verdict();
  end
endmodule : testbench
